// file: verilog/pct_pkg.sv
// Summary of operation
// RULE1: Minimum grant byte always reads three.
// RULE2: Interrupt pin byte reads one, read-only.
// RULE3: Interrupt routing byte read/write, resets to 0xFF.
// RULE4: Software writes controller input; device stores it.
// RULE5: Upper subsystem half writable, feeds product alias.
// RULE6: Lower subsystem half writable, feeds maker alias.
// RULE7: Firmware may preload subsystem codes before enumeration.
// RULE8: Major revision one; top byte reads zero.
// RULE9: Minor revision field reads zero.
// RULE10: Following entry pointer reads zero, last entry.
// RULE11: Capability type byte reads 0x02.
// RULE12: List pointer reads 0x44, zero unstrapped.
// RULE13: Read-only writes ignored; byte enables limit writes.
`default_nettype none

package pct_pkg;

  typedef logic [7:0] pct_byte_t;

  ////////////////////////////////////////////////////////////////////////
  // Byte offsets in configuration space
  localparam logic [7:0] OFF_ALIAS_SUBSYS = 8'h2C;
  localparam logic [7:0] OFF_CAP_LIST_PTR = 8'h34;
  localparam logic [7:0] OFF_IRQ_ROUTE = 8'h3C;
  localparam logic [7:0] OFF_IRQ_PIN = 8'h3D;
  localparam logic [7:0] OFF_MIN_GRANT = 8'h3E;
  localparam logic [7:0] OFF_MAX_LAT = 8'h3F;
  localparam logic [7:0] OFF_WR_SUBSYS = 8'h40;
  localparam logic [7:0] OFF_CAP_HDR = 8'h44;

  ////////////////////////////////////////////////////////////////////////
  // Burst timing, in units of the grant quantum
  localparam int GRANT_UNIT_NS = 250;
  localparam int BURST_TIME_NS = 750;
  localparam pct_byte_t MIN_GRANT_VAL = 8'(BURST_TIME_NS / GRANT_UNIT_NS);
  localparam pct_byte_t MAX_LAT_VAL = 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Fixed and reset values
  localparam pct_byte_t IRQ_PIN_VAL = 8'h01;
  localparam pct_byte_t IRQ_ROUTE_RST = 8'hFF;
  localparam pct_byte_t SUBSYS_BYTE_RST = 8'h00;
  localparam logic [3:0] CAP_REV_MAJOR = 4'h1;
  localparam logic [3:0] CAP_REV_MINOR = 4'h0;
  localparam pct_byte_t CAP_HDR_RSVD = 8'h00;
  localparam pct_byte_t FOLLOWING_PTR_VAL = 8'h00;
  localparam pct_byte_t CAP_TYPE_VAL = 8'h02;
  localparam pct_byte_t CAP_LIST_PTR_VAL = OFF_CAP_HDR;
  localparam pct_byte_t CAP_LIST_PTR_NONE = 8'h00;
  localparam logic [23:0] PTR_RSVD = 24'h000000;
  localparam logic [31:0] DWORD_ZERO = 32'h00000000;
  localparam logic STRAP_RST = 1'b0;

endpackage

`default_nettype wire

// file: verilog/pct_cfg_byte.sv
`default_nettype none

// One byte-lane of a read/write configuration field
module pct_cfg_byte #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] value_r
);

  wire logic [WIDTH-1:0] value_nxt;

  assign value_nxt = wrEn ? wrData : value_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= RST_VAL;
    end else if (ce) begin
      value_r <= value_nxt;
    end
  end

endmodule

`default_nettype wire

// file: verilog/pct_level_sync.sv
`default_nettype none

// Two-stage synchroniser for a level from a pin
module pct_level_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic asyncIn,
  output logic syncOut_r
);

  logic stage1_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_r <= RST_VAL;
      syncOut_r <= RST_VAL;
    end else if (ce) begin
      stage1_r <= asyncIn;
      syncOut_r <= stage1_r;
    end
  end

endmodule

`default_nettype wire

// file: verilog/pct_cfg_tail.sv
`default_nettype none

module pct_cfg_tail (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic graphicsPortStrap,
  output logic cfgAck_r,
  output logic cfgHit_r,
  output logic [31:0] cfgRdData_r,
  output pct_pkg::pct_byte_t irqRouteNumber,
  output logic [15:0] boardProductCodeField,
  output logic [15:0] boardMakerCodeField,
  output pct_pkg::pct_byte_t capabilityListPointer_r
);

  import pct_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Request and address decode

  wire logic reqTaken;
  wire logic rdTaken;
  wire logic wrTaken;
  wire logic [5:0] dwordIdx;
  wire logic hitAlias;
  wire logic hitCapPtr;
  wire logic hitIrq;
  wire logic hitWrSubsys;
  wire logic hitCapHdr;
  wire logic hitAny;

  assign reqTaken = cfgReq && ce;
  assign rdTaken = reqTaken && !cfgWrite;
  assign wrTaken = reqTaken && cfgWrite;
  // Lane bits of the address are ignored; byte enables pick lanes
  assign dwordIdx = cfgAddr[7:2];
  assign hitAlias = dwordIdx == OFF_ALIAS_SUBSYS[7:2];
  assign hitCapPtr = dwordIdx == OFF_CAP_LIST_PTR[7:2];
  assign hitIrq = dwordIdx == OFF_IRQ_ROUTE[7:2];
  assign hitWrSubsys = dwordIdx == OFF_WR_SUBSYS[7:2];
  assign hitCapHdr = dwordIdx == OFF_CAP_HDR[7:2];
  assign hitAny = hitAlias || hitCapPtr || hitIrq || hitWrSubsys || hitCapHdr;

  ////////////////////////////////////////////////////////////////////////
  // Write strobes, one per writable byte lane

  wire logic irqWrEn;
  wire logic [3:0] subsysWrEn;

  assign irqWrEn = wrTaken && hitIrq && cfgByteEn[OFF_IRQ_ROUTE[1:0]]; // RULE3 RULE13
  assign subsysWrEn = {4{wrTaken && hitWrSubsys}} & cfgByteEn; // RULE13

  ////////////////////////////////////////////////////////////////////////
  // Writable fields

  pct_cfg_byte #(
    .WIDTH(8),
    .RST_VAL(IRQ_ROUTE_RST)
  ) u_irq_route (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wrEn(irqWrEn),
    .wrData(cfgWrData[7:0]),
    .value_r(irqRouteNumber)
  ); // RULE3

  wire logic [31:0] subsysWord;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_subsys
      pct_cfg_byte #(
        .WIDTH(8),
        .RST_VAL(SUBSYS_BYTE_RST)
      ) u_subsys_byte (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .wrEn(subsysWrEn[lane]),
        .wrData(cfgWrData[lane*8 +: 8]),
        .value_r(subsysWord[lane*8 +: 8])
      ); // RULE5 RULE6
    end
  endgenerate

  assign boardProductCodeField = subsysWord[31:16]; // RULE5
  assign boardMakerCodeField = subsysWord[15:0]; // RULE6

  ////////////////////////////////////////////////////////////////////////
  // Graphics-port strap and capability list pointer

  wire logic strapSync;
  pct_byte_t capPtr_nxt;

  pct_level_sync #(
    .RST_VAL(STRAP_RST)
  ) u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .asyncIn(graphicsPortStrap),
    .syncOut_r(strapSync)
  );

  assign capPtr_nxt = strapSync ? CAP_LIST_PTR_VAL : CAP_LIST_PTR_NONE; // RULE12

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capabilityListPointer_r <= CAP_LIST_PTR_NONE;
    end else if (ce) begin
      capabilityListPointer_r <= capPtr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data assembly

  wire logic [31:0] irqDword;
  wire logic [31:0] capHdrDword;
  wire logic [31:0] capPtrDword;
  wire logic [31:0] rdWord;

  assign irqDword = {MAX_LAT_VAL, MIN_GRANT_VAL, IRQ_PIN_VAL, irqRouteNumber}; // RULE1 RULE2
  assign capHdrDword = {CAP_HDR_RSVD, CAP_REV_MAJOR, CAP_REV_MINOR,
                        FOLLOWING_PTR_VAL, CAP_TYPE_VAL}; // RULE8 RULE9 RULE10 RULE11
  assign capPtrDword = {PTR_RSVD, capabilityListPointer_r}; // RULE12
  assign rdWord = hitIrq ? irqDword :
                  hitWrSubsys ? subsysWord :
                  hitAlias ? subsysWord :
                  hitCapHdr ? capHdrDword :
                  hitCapPtr ? capPtrDword :
                  DWORD_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Answer registers, one cycle after the request

  wire logic [31:0] rdData_nxt;
  wire logic hit_nxt;

  assign rdData_nxt = rdTaken ? rdWord : DWORD_ZERO;
  assign hit_nxt = reqTaken && hitAny;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgAck_r <= 1'b0;
      cfgHit_r <= 1'b0;
      cfgRdData_r <= DWORD_ZERO;
    end else if (ce) begin
      cfgAck_r <= cfgReq;
      cfgHit_r <= hit_nxt;
      cfgRdData_r <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  sequence rdAt(logic hitSel);
    rdTaken && hitSel;
  endsequence

  min_grant_const_a: assert property ( // RULE1
    rdAt(hitIrq) |=> cfgRdData_r[23:16] == 8'h03 && cfgAck_r
  ) else $error("minimum grant byte not three");

  irq_pin_const_a: assert property ( // RULE2
    rdAt(hitIrq) |=> cfgRdData_r[15:8] == 8'h01
  ) else $error("interrupt pin byte not one");

  irq_route_rst_a: assert property ( // RULE3
    disable iff (1'b0)
    !rst_n |=> irqRouteNumber == 8'hFF
  ) else $error("interrupt routing byte not 0xFF after reset");

  irq_route_wr_a: assert property ( // RULE3
    wrTaken && hitIrq && cfgByteEn[0] |=> irqRouteNumber == $past(cfgWrData[7:0])
  ) else $error("interrupt routing byte lost written value");

  irq_route_read_a: assert property ( // RULE3
    rdAt(hitIrq) |=> cfgRdData_r[7:0] == $past(irqRouteNumber)
  ) else $error("interrupt routing byte read back wrong");

  product_alias_a: assert property ( // RULE5
    wrTaken && hitWrSubsys && cfgByteEn[3:2] == 2'b11
    |=> boardProductCodeField == $past(cfgWrData[31:16])
  ) else $error("product code not updated by write");

  maker_alias_a: assert property ( // RULE6
    wrTaken && hitWrSubsys && cfgByteEn[1:0] == 2'b11
    |=> boardMakerCodeField == $past(cfgWrData[15:0])
  ) else $error("maker code not updated by write");

  alias_read_a: assert property ( // RULE6
    rdAt(hitAlias)
    |=> cfgRdData_r == {$past(boardProductCodeField), $past(boardMakerCodeField)}
  ) else $error("alias read differs from writable copy");

  subsys_rst_a: assert property ( // RULE6
    disable iff (1'b0)
    !rst_n |=> boardProductCodeField == 16'h0000 && boardMakerCodeField == 16'h0000
  ) else $error("subsystem codes not zero after reset");

  cap_revision_a: assert property ( // RULE8
    rdAt(hitCapHdr) |=> cfgRdData_r[31:20] == 12'h001
  ) else $error("major revision or reserved byte wrong");

  minor_rev_a: assert property ( // RULE9
    rdAt(hitCapHdr) |=> cfgRdData_r[19:16] == 4'h0
  ) else $error("minor revision not zero");

  following_entry_pointer_null_a: assert property ( // RULE10
    rdAt(hitCapHdr) |=> cfgRdData_r[15:8] == 8'h00
  ) else $error("following entry pointer not null");

  cap_type_a: assert property ( // RULE11
    rdAt(hitCapHdr) |=> cfgRdData_r[7:0] == 8'h02
  ) else $error("capability type byte not 0x02");

  capability_list_pointer_read_a: assert property ( // RULE12
    ce && strapSync ##1 ce && rdTaken && hitCapPtr |=> cfgRdData_r == 32'h00000044
  ) else $error("list pointer wrong while strapped");

  capability_list_pointer_none_a: assert property ( // RULE12
    ce && !strapSync ##1 ce && rdTaken && hitCapPtr |=> cfgRdData_r == 32'h00000000
  ) else $error("list pointer not zero while unstrapped");

  capability_list_pointer_follow_a: assert property ( // RULE12
    ce && strapSync |=> capabilityListPointer_r == 8'h44
  ) else $error("list pointer port wrong while strapped");

  capability_list_pointer_clear_a: assert property ( // RULE12
    ce && !strapSync |=> capabilityListPointer_r == 8'h00
  ) else $error("list pointer port not zero while unstrapped");

  ro_write_ign_a: assert property ( // RULE13
    wrTaken && hitIrq && !cfgByteEn[0] |=> $stable(irqRouteNumber)
  ) else $error("disabled lane changed routing byte");

  lane_limit_a: assert property ( // RULE13
    wrTaken && hitWrSubsys && cfgByteEn == 4'b0001
    |=> subsysWord[31:8] == $past(subsysWord[31:8])
        && subsysWord[7:0] == $past(cfgWrData[7:0])
  ) else $error("write spilled beyond enabled lane");

  alias_wr_ign_a: assert property ( // RULE13
    wrTaken && hitAlias |=> $stable(subsysWord)
  ) else $error("write to alias changed subsystem codes");

  ro_write_ack_a: assert property ( // RULE13
    wrTaken |=> cfgAck_r && cfgRdData_r == 32'h00000000
  ) else $error("write not answered cleanly");

  irq_route_hold_a: assert property ( // RULE13
    !(wrTaken && hitIrq && cfgByteEn[0]) |=> $stable(irqRouteNumber)
  ) else $error("routing byte changed without a write");

  subsys_hold_a: assert property ( // RULE13
    !(wrTaken && hitWrSubsys) |=> $stable(subsysWord)
  ) else $error("subsystem codes changed without a write");

  ce_freeze_a: assert property ( // RULE3 RULE5 RULE6
    !ce |=> $stable(irqRouteNumber) && $stable(subsysWord) && $stable(cfgAck_r)
        && $stable(cfgRdData_r) && $stable(capabilityListPointer_r)
  ) else $error("state moved while clock enable low");

  ////////////////////////////////////////////////////////////////////////
  // Scenario covers

  cov_irq_write_c: cover property (
    wrTaken && hitIrq && cfgByteEn[0] ##[1:4] rdTaken && hitIrq
  );

  cov_alias_preload_c: cover property (
    wrTaken && hitWrSubsys && cfgByteEn == 4'hF ##[1:4] rdTaken && hitAlias
  );

  cov_cap_walk_c: cover property (
    rdTaken && hitCapPtr && strapSync ##[1:4] rdTaken && hitCapHdr
  );

  cov_unstrapped_c: cover property (
    rdTaken && hitCapPtr && !strapSync
  );

  cov_freeze_c: cover property (
    !ce && cfgReq
  );

endmodule

`default_nettype wire

// file: verification/pct_host_model.sv
`default_nettype none

// Host bridge issuing single configuration cycles
module pct_host_model (
  input wire logic clk,
  input wire logic cfgAck_r,
  input wire logic cfgHit_r,
  input wire logic [31:0] cfgRdData_r,
  output logic cfgReq,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // One access, answer taken at the edge after the taking edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
      input logic [31:0] data, output logic ack, output logic hit, output logic [31:0] rd);
    @(posedge clk);
    cfgReq <= 1'b1;
    cfgWrite <= wr;
    cfgAddr <= addr;
    cfgByteEn <= be;
    cfgWrData <= data;
    @(posedge clk);
    cfgReq <= 1'b0;
    cfgAddr <= ~addr;
    cfgWrData <= ~data;
    @(posedge clk);
    ack = cfgAck_r;
    hit = cfgHit_r;
    rd = cfgRdData_r;
  endtask
endmodule

`default_nettype wire

// file: verification/pct_cfg_tail_tb.sv
`default_nettype none

module pct_cfg_tail_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pct_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic strap = 1'b0;
  logic cfgReq, cfgWrite, cfgAck, cfgHit, ack, hit;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData, rd;
  pct_byte_t irqRoute, capPtr;
  logic [15:0] product, maker;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  pct_cfg_tail pct_cfg_tail_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .cfgReq(cfgReq),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .graphicsPortStrap(strap), .cfgAck_r(cfgAck), .cfgHit_r(cfgHit), .cfgRdData_r(cfgRdData),
    .irqRouteNumber(irqRoute), .boardProductCodeField(product),
    .boardMakerCodeField(maker), .capabilityListPointer_r(capPtr));

  pct_host_model pct_host_model_inst (.clk(clk), .cfgAck_r(cfgAck), .cfgHit_r(cfgHit),
    .cfgRdData_r(cfgRdData), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData));

  ////////////////////////////////////////////////////////////////////////
  task automatic finishTest;
    if (errCount == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      finishTest;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input string what, input logic [7:0] addr, input logic [31:0] exp,
      input logic expHit);
    pct_host_model_inst.access(1'b0, addr, 4'hF, 32'h00000000, ack, hit, rd);
    chk({what, " ack"}, 32'h00000001, {31'h0, ack});
    chk({what, " hit"}, {31'h0, expHit}, {31'h0, hit});
    chk(what, exp, rd);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
    pct_host_model_inst.access(1'b1, addr, be, data, ack, hit, rd);
    chk("write ack", 32'h00000001, {31'h0, ack});
    chk("write data", 32'h00000000, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic testResetValues;
    rdChk("tail", OFF_IRQ_ROUTE, 32'h010301FF, 1'b1);
    rdChk("subsys", OFF_WR_SUBSYS, 32'h00000000, 1'b1);
    rdChk("cap hdr", OFF_CAP_HDR, 32'h00100002, 1'b1);
    rdChk("capability_list_pointer", OFF_CAP_LIST_PTR, 32'h00000000, 1'b1);
  endtask

  task automatic testIrqRoute;
    wr(OFF_IRQ_ROUTE, 4'hF, 32'hFFFFFF0F);
    rdChk("tail", OFF_IRQ_ROUTE, 32'h0103010F, 1'b1);
    wr(OFF_IRQ_ROUTE, 4'hE, 32'h000000A5);
    rdChk("tail", OFF_IRQ_ROUTE, 32'h0103010F, 1'b1);
    chk("irq route", 32'h0000000F, {24'h0, irqRoute});
  endtask

  task automatic testSubsys;
    wr(OFF_WR_SUBSYS, 4'h5, 32'h12345678);
    rdChk("subsys", OFF_WR_SUBSYS, 32'h00340078, 1'b1);
    wr(OFF_ALIAS_SUBSYS, 4'hF, 32'hFFFFFFFF);
    rdChk("alias", OFF_ALIAS_SUBSYS, 32'h00340078, 1'b1);
    chk("product", 32'h00000034, {16'h0, product});
    chk("maker", 32'h00000078, {16'h0, maker});
    wr(OFF_WR_SUBSYS, 4'hF, 32'hA1B2C3D4);
    rdChk("alias", OFF_ALIAS_SUBSYS, 32'hA1B2C3D4, 1'b1);
    wr(OFF_WR_SUBSYS, 4'h1, 32'h000000EE);
    rdChk("subsys", OFF_WR_SUBSYS, 32'hA1B2C3EE, 1'b1);
  endtask

  task automatic testClockEnable;
    @(posedge clk);
    ce <= 1'b0;
    pct_host_model_inst.access(1'b1, OFF_IRQ_ROUTE, 4'hF, 32'h00000033, ack, hit, rd);
    chk("frozen ack", 32'h00000000, {31'h0, ack});
    chk("frozen route", 32'h0000000F, {24'h0, irqRoute});
    ce <= 1'b1;
    rdChk("tail", OFF_IRQ_ROUTE, 32'h0103010F, 1'b1);
  endtask

  task automatic testMidReset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdChk("tail", OFF_IRQ_ROUTE, 32'h010301FF, 1'b1);
    rdChk("alias", OFF_ALIAS_SUBSYS, 32'h00000000, 1'b1);
    chk("irq route", 32'h000000FF, {24'h0, irqRoute});
  endtask

  task automatic testReadOnly;
    wr(OFF_CAP_HDR, 4'hF, 32'hFFFFFFFF);
    rdChk("cap hdr", OFF_CAP_HDR, 32'h00100002, 1'b1);
    wr(8'h50, 4'hF, 32'hFFFFFFFF);
    rdChk("unmapped", 8'h50, 32'h00000000, 1'b0);
  endtask

  task automatic testStrap;
    @(posedge clk);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    rdChk("capability_list_pointer", OFF_CAP_LIST_PTR, 32'h00000044, 1'b1);
    chk("capability_list_pointer port", 32'h00000044, {24'h0, capPtr});
    rdChk("cap hdr", OFF_CAP_HDR, 32'h00100002, 1'b1);
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    rdChk("capability_list_pointer", OFF_CAP_LIST_PTR, 32'h00000000, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    testResetValues;
    testIrqRoute;
    testClockEnable;
    testSubsys;
    testReadOnly;
    testStrap;
    testMidReset;
    finishTest;
  end
endmodule

`default_nettype wire
